// *** rtl/stm_defines.svh ***
`ifndef STM_DEFINES_SVH
`define STM_DEFINES_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define STM_OFF_CTRL0 4'h0
`define STM_OFF_CTRL1 4'h1
`define STM_OFF_CNT_LO 4'h2
`define STM_OFF_CNT_HI 4'h3
`define STM_OFF_A_COMPARE_VALUE_LO 4'h4
`define STM_OFF_A_COMPARE_VALUE_HI 4'h5
`define STM_OFF_PERIOD 4'h6
`define STM_OFF_FLAGS 4'h7
// ----------------------------------------
// field positions
// ----------------------------------------
`define STM_C0_PAUSE 7
`define STM_C0_CKSEL_HI 6
`define STM_C0_CKSEL_LO 4
`define STM_C0_ENABLE 3
`define STM_C1_CCLR 0
`define STM_C1_DPX 1
`define STM_C1_POL 2
`define STM_C1_OC 3
`define STM_FL_A 0
`define STM_FL_P 1
// ----------------------------------------
// reset values and encodings
// ----------------------------------------
`define STM_RST_BYTE 8'h00
`define STM_RST_WORD 16'h0000
`define STM_MODE_CMP 2'h0
`define STM_MODE_CAP 2'h1
`define STM_MODE_PWM 2'h2
`define STM_MODE_TMR 2'h3
`define STM_IO_00 2'h0
`define STM_IO_01 2'h1
`define STM_IO_10 2'h2
`define STM_IO_11 2'h3
`define STM_CK_SYS4 3'h0
`define STM_CK_SYS 3'h1
`define STM_CK_H16 3'h2
`define STM_CK_H64 3'h3
`define STM_CK_TBC 3'h4
`define STM_CK_EXTR 3'h6
`define STM_CK_EXTF 3'h7
`define STM_PRESC_W 6
`endif

// *** rtl/stm_pkg.sv ***
package stm_pkg;
	// all state of the timer in one word
	typedef struct packed {
		logic [7:0] ctrl0;
		logic [7:0] ctrl1;
		logic [7:0] period;
		logic [15:0] a_compare_value;
		logic [15:0] count;
		logic [1:0] flags;
		logic [7:0] rdata;
		logic [5:0] presc;
		logic en_prev;
		logic pin;
		logic oe_n;
		logic ext_s1;
		logic ext_s2;
		logic ext_prev;
		logic cap_s1;
		logic cap_s2;
		logic cap_prev;
	} stm_state_t;
endpackage

// *** rtl/stm_timer.sv ***
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "stm_defines.svh"
module stm_timer
	import stm_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic i_ext_clock_pin,
	input wire logic i_capture_pin,
	input wire logic i_clk_h16,
	input wire logic i_clk_h64,
	input wire logic i_clk_tbc,
	output logic [7:0] o_rdata,
	output logic o_timer_output_pin,
	output logic o_pin_oe_n,
	output logic o_a_match_flag,
	output logic o_p_match_flag
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	stm_state_t q; // registered state
	stm_state_t d; // next state
	logic [1:0] mode; // operating mode
	logic [1:0] io; // pin function
	logic enable; // module enable bit
	logic en_rise; // enable rising transition
	logic tick; // counter clock enable
	logic ext_edge; // selected external edge
	logic ext_rise; // external rising edge
	logic ext_fall; // external falling edge
	logic cap_edge; // capture edge event
	logic p_match; // comparator p match
	logic a_match; // comparator a match
	logic is_pwm; // pwm output mode
	logic is_pulse; // single pulse mode
	logic pwm_act; // pwm active phase
	logic pwm_lvl; // pwm pin level
	logic [16:0] per_len; // period byte span
	logic [15:0] nxt_cnt; // counter plus one
	logic wr_flags; // write to flags
	// ----------------------------------------
	// decode
	// ----------------------------------------
	logic pause; // counter pause bit
	logic [2:0] ck_sel; // counter clock source
	logic clr_sel; // clear-select bit
	logic swap; // duty/period swap bit
	logic pol; // output polarity bit
	logic oc; // output-control bit
	logic [16:0] cnt_ext; // counter widened for compares
	logic [16:0] nxt_ext; // counter plus one, widened
	logic [16:0] a_compare_value_ext; // a compare widened
	logic cap_rise; // capture pin rising edge
	logic cap_fall; // capture pin falling edge
	logic act_lvl; // pin level in active phase
	logic idle_lvl; // pin level in inactive phase
	logic clr_cnt; // counter clears on this tick
	logic set_a; // raise the a flag
	logic set_p; // raise the p flag
	logic src_tick; // selected source pulse
	// decode control bits
	always_comb begin
		mode = q.ctrl1[7:6];
		io = q.ctrl1[5:4];
		oc = q.ctrl1[`STM_C1_OC];
		pol = q.ctrl1[`STM_C1_POL];
		swap = q.ctrl1[`STM_C1_DPX];
		clr_sel = q.ctrl1[`STM_C1_CCLR];
		pause = q.ctrl0[`STM_C0_PAUSE];
		ck_sel = q.ctrl0[`STM_C0_CKSEL_HI:`STM_C0_CKSEL_LO];
		enable = q.ctrl0[`STM_C0_ENABLE];
		en_rise = enable && !q.en_prev;
		is_pwm = (mode == `STM_MODE_PWM) && (io != `STM_IO_11);
		is_pulse = (mode == `STM_MODE_PWM) && (io == `STM_IO_11);
		wr_flags = i_wr && (i_addr == `STM_OFF_FLAGS);
	end
	// ----------------------------------------
	// pin edges
	// ----------------------------------------
	// edges compare the second sync stage with its delayed copy,
	// so the first stage never feeds logic directly
	always_comb begin
		ext_rise = q.ext_s2 && !q.ext_prev;
		ext_fall = !q.ext_s2 && q.ext_prev;
		cap_rise = q.cap_s2 && !q.cap_prev;
		cap_fall = !q.cap_s2 && q.cap_prev;
		// falling select picks the falling edge, else rising
		if (ck_sel == `STM_CK_EXTF) begin
			ext_edge = ext_fall;
		end else begin
			ext_edge = ext_rise;
		end
		// capture edge chosen by the pin-function bits
		unique case (io)
			`STM_IO_00: cap_edge = cap_rise;
			`STM_IO_01: cap_edge = cap_fall;
			`STM_IO_10: cap_edge = cap_rise || cap_fall;
			`STM_IO_11: cap_edge = 1'b0;
		endcase
	end
	// ----------------------------------------
	// counter clock
	// ----------------------------------------
	// one-cycle enable pulse from the selected source
	always_comb begin
		unique case (ck_sel)
			`STM_CK_SYS4: src_tick = (q.presc[1:0] == 2'h3); // divide by four
			`STM_CK_SYS: src_tick = 1'b1; // every clock
			`STM_CK_H16: src_tick = i_clk_h16;
			`STM_CK_H64: src_tick = i_clk_h64;
			`STM_CK_TBC: src_tick = i_clk_tbc;
			`STM_CK_EXTR: src_tick = ext_rise;
			`STM_CK_EXTF: src_tick = ext_fall;
			default: src_tick = 1'b0; // reserved code stops the counter
		endcase
		// counting needs the module on and not paused
		tick = src_tick && enable && !pause;
	end
	// ----------------------------------------
	// comparators
	// ----------------------------------------
	// compares run one bit wider so a zero period can mean 65536
	always_comb begin
		cnt_ext = {1'b0, q.count};
		nxt_ext = cnt_ext + 17'h00001;
		nxt_cnt = nxt_ext[15:0]; // wraps to zero past the top
		a_compare_value_ext = {1'b0, q.a_compare_value};
		if (q.period == `STM_RST_BYTE) begin
			per_len = 17'h10000;
		end else begin
			per_len = {1'b0, q.period, 8'h00};
		end
		// matches fire on the tick that would reach the value
		p_match = tick && (nxt_ext == per_len);
		a_match = tick && (nxt_ext == a_compare_value_ext);
	end
	// ----------------------------------------
	// pwm waveform
	// ----------------------------------------
	// active phase and pin levels
	always_comb begin
		if (swap) begin
			pwm_act = cnt_ext < per_len;
		end else begin
			pwm_act = cnt_ext < a_compare_value_ext;
		end
		act_lvl = oc ^ pol;
		idle_lvl = ~oc ^ pol;
		// forced levels leave the counting untouched
		unique case (io)
			`STM_IO_00: pwm_lvl = idle_lvl;
			`STM_IO_01: pwm_lvl = act_lvl;
			`STM_IO_10: pwm_lvl = pwm_act ? act_lvl : idle_lvl;
			`STM_IO_11: pwm_lvl = idle_lvl; // single pulse handled apart
		endcase
	end
	// ----------------------------------------
	// next state
	// ----------------------------------------
	// all register, counter, flag and pin updates
	always_comb begin
		d = q;
		set_a = 1'b0;
		set_p = 1'b0;
		clr_cnt = 1'b0;
		d.rdata = `STM_RST_BYTE; // read data stands one cycle
		d.presc = q.presc + 6'h01; // free running divider
		// two-stage synchronisers and delayed copies
		d.ext_s1 = i_ext_clock_pin;
		d.ext_s2 = q.ext_s1;
		d.ext_prev = q.ext_s2;
		d.cap_s1 = i_capture_pin;
		d.cap_s2 = q.cap_s1;
		d.cap_prev = q.cap_s2;
		d.en_prev = enable;
		// software writes
		if (i_wr) begin
			unique case (i_addr)
				`STM_OFF_CTRL0: d.ctrl0 = {i_wdata[7:3], 3'h0}; // low bits unused
				`STM_OFF_CTRL1: d.ctrl1 = i_wdata;
				`STM_OFF_A_COMPARE_VALUE_LO: d.a_compare_value[7:0] = i_wdata;
				`STM_OFF_A_COMPARE_VALUE_HI: d.a_compare_value[15:8] = i_wdata;
				`STM_OFF_PERIOD: d.period = i_wdata;
				default: ; // counter is read only, flags below
			endcase
		end
		// flags clear where software writes zero
		if (wr_flags) begin
			d.flags = q.flags & i_wdata[1:0];
		end
		// counter and match handling per mode
		if (en_rise) begin
			d.count = `STM_RST_WORD;
		end else if (tick) begin
			unique case (mode)
				`STM_MODE_CMP, `STM_MODE_TMR: begin
					if (clr_sel) begin
						clr_cnt = a_match;
						set_a = a_match;
					end else begin
						clr_cnt = p_match;
						set_a = a_match;
						set_p = p_match;
					end
				end
				`STM_MODE_PWM: begin
					if (is_pulse) begin
						set_a = a_match;
					end else if (swap) begin
						clr_cnt = a_match;
						set_a = a_match;
						set_p = p_match;
					end else begin
						clr_cnt = p_match;
						set_a = a_match;
						set_p = p_match;
					end
				end
				`STM_MODE_CAP: begin
					clr_cnt = p_match;
					set_p = p_match;
				end
			endcase
			// single pulse only returns to zero on enable rise
			if (clr_cnt) begin
				d.count = `STM_RST_WORD;
			end else begin
				d.count = nxt_cnt;
			end
		end
		// capture latches the running count into the a register
		if ((mode == `STM_MODE_CAP) && enable && cap_edge) begin
			d.a_compare_value = q.count;
			set_a = 1'b1;
		end
		// single pulse: pin edge starts, a match ends
		if (is_pulse) begin
			if (ext_edge) begin
				d.ctrl0[`STM_C0_ENABLE] = 1'b1;
			end
			if (a_match) begin
				d.ctrl0[`STM_C0_ENABLE] = 1'b0;
			end
		end
		// a raising event wins over a clear in the same cycle
		d.flags = d.flags | {set_p, set_a};
		// output pin per mode
		unique case (mode)
			`STM_MODE_CMP: begin
				if (en_rise) begin
					d.pin = oc;
				end else if (a_match) begin
					// only comparator a moves the pin
					unique case (io)
						`STM_IO_00: d.pin = q.pin;
						`STM_IO_01: d.pin = 1'b0;
						`STM_IO_10: d.pin = 1'b1;
						`STM_IO_11: d.pin = ~q.pin;
					endcase
				end
			end
			`STM_MODE_PWM: begin
				if (is_pwm) begin
					if (enable) begin
						d.pin = pwm_lvl;
					end else begin
						d.pin = idle_lvl;
					end
				end else if (d.ctrl0[`STM_C0_ENABLE]) begin
					d.pin = act_lvl;
				end else begin
					d.pin = idle_lvl;
				end
			end
			`STM_MODE_CAP, `STM_MODE_TMR: begin
				d.pin = q.pin;
			end
		endcase
		// capture and timer modes leave the pin to others
		d.oe_n = (mode == `STM_MODE_CAP) || (mode == `STM_MODE_TMR);
		// register reads, answered in the next cycle
		if (i_rd) begin
			unique case (i_addr)
				`STM_OFF_CTRL0: d.rdata = q.ctrl0;
				`STM_OFF_CTRL1: d.rdata = q.ctrl1;
				`STM_OFF_CNT_LO: d.rdata = q.count[7:0];
				`STM_OFF_CNT_HI: d.rdata = q.count[15:8];
				`STM_OFF_A_COMPARE_VALUE_LO: d.rdata = q.a_compare_value[7:0];
				`STM_OFF_A_COMPARE_VALUE_HI: d.rdata = q.a_compare_value[15:8];
				`STM_OFF_PERIOD: d.rdata = q.period;
				`STM_OFF_FLAGS: d.rdata = {6'h00, q.flags};
				default: d.rdata = `STM_RST_BYTE; // unused offsets read zero
			endcase
		end
	end
	// ----------------------------------------
	// state register
	// ----------------------------------------
	// asynchronous reset clears everything
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// every output taken straight from the state register
	assign o_rdata = q.rdata;
	assign o_timer_output_pin = q.pin;
	assign o_pin_oe_n = q.oe_n;
	assign o_a_match_flag = q.flags[`STM_FL_A];
	assign o_p_match_flag = q.flags[`STM_FL_P];
endmodule

// *** sim/stm_timer_checker.sv ***
`timescale 1ns/1ps
module stm_timer_checker (
	input logic i_ref_clk,
	input logic i_reset_n,
	input logic [3:0] i_addr,
	input logic [7:0] i_wdata,
	input logic i_wr,
	input logic i_rd,
	input logic [7:0] o_rdata,
	input logic o_a_match_flag,
	input logic o_p_match_flag
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_reset_n);
	logic [7:0] c1_q; // shadow of control byte one
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			c1_q <= 8'h00;
		end else if (i_wr && i_addr == 4'h1) begin
			c1_q <= i_wdata;
		end
	end
	AST_AF_HOLD: assert property (o_a_match_flag && !(i_wr && i_addr == 4'h7)
		|=> o_a_match_flag) else $error("a flag lost");
	AST_NO_PF: assert property (c1_q == 8'h01 |=> !$rose(o_p_match_flag))
		else $error("p flag raised");
	AST_RP_RB: assert property (i_wr && i_addr == 4'h6 ##1 i_rd && i_addr == 4'h6
		|=> o_rdata == $past(i_wdata, 2)) else $error("period readback");
	AST_PF_HOLD: assert property (o_p_match_flag && !(i_wr && i_addr == 4'h7)
		|=> o_p_match_flag) else $error("p flag lost");
	AST_FLAG_RB: assert property (i_rd && i_addr == 4'h7
		|=> o_rdata == {6'h00, $past(o_p_match_flag), $past(o_a_match_flag)})
		else $error("flag readback");
	AST_C1_RB: assert property (i_wr && i_addr == 4'h1 ##1 i_rd && i_addr == 4'h1
		|=> o_rdata == $past(i_wdata, 2)) else $error("control readback");
	AST_C_A: cover property ($rose(o_a_match_flag));
	AST_C_CAP: cover property (c1_q == 8'h40 && o_a_match_flag);
	AST_C_RB: cover property (i_rd && i_addr == 4'h6);
endmodule
bind stm_timer stm_timer_checker stm_timer_checker_inst (.*);

// *** sim/stm_pin_model.sv ***
`timescale 1ns/1ps
module stm_pin_model (
	input logic i_ref_clk,
	input logic i_go,
	output logic o_capture_pin = 1'b0
);
	// one held level change per request
	always @(posedge i_ref_clk) if (i_go) o_capture_pin <= !o_capture_pin;
endmodule

// *** sim/tb_stm_timer.sv ***
`timescale 1ns/1ps
module tb_stm_timer;
	logic i_ref_clk = 0, i_reset_n = 0, i_wr = 0, i_rd = 0, go = 0, i_capture_pin;
	logic i_ext_clock_pin = 0, i_clk_h16 = 0, i_clk_h64 = 0, i_clk_tbc = 0;
	logic [3:0] i_addr = 0;
	logic [7:0] i_wdata = 0, o_rdata;
	logic o_timer_output_pin, o_pin_oe_n, o_a_match_flag, o_p_match_flag;
	int num_errors = 0, checks_done = 0;
	always #12.5 i_ref_clk = !i_ref_clk;
	stm_pin_model stm_pin_model_inst (.i_ref_clk, .i_go(go), .o_capture_pin(i_capture_pin));
	stm_timer stm_timer_inst (
		.i_ref_clk(i_ref_clk),
		.i_reset_n(i_reset_n),
		.i_addr(i_addr),
		.i_wdata(i_wdata),
		.i_wr(i_wr),
		.i_rd(i_rd),
		.i_ext_clock_pin(i_ext_clock_pin),
		.i_capture_pin(i_capture_pin),
		.i_clk_h16(i_clk_h16),
		.i_clk_h64(i_clk_h64),
		.i_clk_tbc(i_clk_tbc),
		.o_rdata(o_rdata),
		.o_timer_output_pin(o_timer_output_pin),
		.o_pin_oe_n(o_pin_oe_n),
		.o_a_match_flag(o_a_match_flag),
		.o_p_match_flag(o_p_match_flag)
	);
	task automatic cmp(input logic [7:0] g, input logic [7:0] e);
		checks_done++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask
	// write strobe stays up for back-to-back writes
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1;
		@(posedge i_ref_clk);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		i_wr <= 0;
		i_addr <= a;
		i_rd <= 1;
		@(posedge i_ref_clk) i_rd <= 0;
		#1 cmp(o_rdata, e);
		@(posedge i_ref_clk);
	endtask
	// bounded wait for the a flag, then both flags compared
	task automatic flags(input logic [7:0] e);
		int n;
		i_wr <= 0;
		n = 0;
		#1;
		while (o_a_match_flag !== 1 && n < 40) begin
			@(posedge i_ref_clk);
			#1 n++;
		end
		if (n == 40) begin
			num_errors++;
			$display("BAD %0t flag wait ran out", $time);
		end
		cmp({6'h00, o_p_match_flag, o_a_match_flag}, e);
	endtask
	task automatic close_out;
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge i_ref_clk);
		i_reset_n <= 1;
		@(posedge i_ref_clk) rd(4'h6, 8'h00);
		wr(4'h6, 8'h5A);
		rd(4'h6, 8'h5A);
		wr(4'h4, 8'h05);
		wr(4'h1, 8'h01);
		rd(4'h1, 8'h01);
		wr(4'h0, 8'h18);
		flags(8'h01);
		rd(4'h7, 8'h01);
		wr(4'h0, 8'h00);
		wr(4'h7, 8'h00);
		wr(4'h1, 8'h40);
		wr(4'h0, 8'h18);
		go <= 1;
		i_wr <= 0;
		@(posedge i_ref_clk) go <= 0;
		flags(8'h01);
		wr(4'h0, 8'h00);
		wr(4'h7, 8'h00);
		wr(4'h4, 8'h08);
		wr(4'h5, 8'h00);
		wr(4'h1, 8'hB8);
		wr(4'h0, 8'h10);
		i_wr <= 0;
		i_ext_clock_pin <= 1;
		repeat (6) @(posedge i_ref_clk);
		#1 cmp({6'h00, o_pin_oe_n, o_timer_output_pin}, 8'h01);
		flags(8'h01);
		cmp({6'h00, o_pin_oe_n, o_timer_output_pin}, 8'h00);
		rd(4'h0, 8'h10);
		close_out;
	end
endmodule
